// [autoneg_partner_status_regs.sv]
// Partner ability and negotiation expansion status registers
// How it works
// - Received base-page word is captured into a read-only register, reset zero.
// - After negotiation with next pages, latest next page replaces base view.
// - Acknowledge bit follows the acknowledge seen in incoming pulse bursts.
// - Base view bits 4:0 hold partner selector, reset zero.
// - Base view bit 12 reads zero.
// - Next view bit 13 is message flag, bits 10:0 code field.
// - Unformatted pages are interpreted by consuming logic, not as messages.
// - Next view bit 12 shows partner can comply.
// - Next view bit 11 shows inverted previous toggle as received.
// - Expansion bits 15:5 read zero; writes do nothing.
// - Expansion bit 4 shows parallel detection fault, zero after reset.
// - Expansion bit 3 shows partner next-page ability.
// - Expansion bit 2 is constant one.
// - Expansion bit 1 sets on page receipt, clears on read.
// - Expansion bit 0 shows partner negotiation ability, zero after reset.
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_status_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [an_partner_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [an_partner_pkg::REG_DATA_W-1:0] reg_wdata,
  output logic [an_partner_pkg::REG_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic base_page_rx,
  input wire logic next_page_rx,
  input wire logic [an_partner_pkg::REG_DATA_W-1:0] rx_page_word,
  input wire logic flp_burst_seen,
  input wire logic flp_burst_ack,
  input wire logic an_done_with_np,
  input wire logic parallel_detect_fault,
  input wire logic partner_negotiation_capable,
  output logic page_view_is_next
);
  import an_partner_pkg::*;

  logic [15:0] base_word;
  logic [15:0] next_word;
  logic partner_ack;
  logic pdf_flag;
  logic partner_an_flag;
  logic page_received;
  logic [15:0] base_view;
  logic [15:0] next_view;
  logic [15:0] expansion_view;
  logic [15:0] next_rdata;
  logic read_expansion;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      base_word <= PAGE_WORD_RESET;
    end else if (base_page_rx) begin
      base_word <= rx_page_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      next_word <= PAGE_WORD_RESET;
    end else if (next_page_rx) begin
      next_word <= rx_page_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      partner_ack <= 1'b0;
    end else if (flp_burst_seen) begin
      partner_ack <= flp_burst_ack;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      page_view_is_next <= 1'b0;
    end else begin
      page_view_is_next <= an_done_with_np;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pdf_flag <= 1'b0;
      partner_an_flag <= 1'b0;
    end else begin
      pdf_flag <= parallel_detect_fault;
      partner_an_flag <= partner_negotiation_capable;
    end
  end

  assign read_expansion = reg_rd && (reg_addr == EXPANSION_STATUS_ADDR);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      page_received <= 1'b0;
    end else if (base_page_rx || next_page_rx) begin
      page_received <= 1'b1;
    end else if (read_expansion) begin
      page_received <= 1'b0;
    end
  end

  always_comb begin
    // base view, reserved bit forced low
    base_view = {base_word[15], partner_ack, base_word[13:0]} & BASE_VIEW_MASK;
    // next view; code passed raw, meaning left to the reader
    next_view = {next_word[15], partner_ack, next_word[13:0]};
    expansion_view = '0;
    expansion_view[PDF_BIT] = pdf_flag;
    expansion_view[PARTNER_NP_BIT] = base_word[NEXT_PAGE_BIT];
    expansion_view[LOCAL_NP_BIT] = LOCAL_NP_VALUE;
    expansion_view[PAGE_RX_BIT] = page_received;
    expansion_view[PARTNER_AN_BIT] = partner_an_flag;
    unique case (reg_addr)
      PARTNER_ABILITY_ADDR: next_rdata = page_view_is_next ? next_view : base_view;
      EXPANSION_STATUS_ADDR: next_rdata = expansion_view;
      default: next_rdata = UNMAPPED_READ_VALUE;
    endcase
  end

  // writes ignored; no write path to the ack bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= READ_DATA_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Assertions
  sequence s_exp_read;
    reg_rd && (reg_addr == EXPANSION_STATUS_ADDR);
  endsequence

  sequence s_ability_read;
    reg_rd && (reg_addr == PARTNER_ABILITY_ADDR);
  endsequence

  sequence s_next_view_read;
    page_view_is_next && reg_rd && (reg_addr == PARTNER_ABILITY_ADDR);
  endsequence

  sequence s_base_view_read;
    !page_view_is_next && reg_rd && (reg_addr == PARTNER_ABILITY_ADDR);
  endsequence

  property p_base_capture;
    @(posedge ref_clk) disable iff (!rstn)
      base_page_rx |=> base_word == $past(rx_page_word);
  endproperty
  a_base_capture: assert property (p_base_capture) else $error("base page not captured");

  property p_view_next;
    @(posedge ref_clk) disable iff (!rstn)
      s_next_view_read |=> reg_rdata[10:0] == $past(next_word[10:0]);
  endproperty
  a_view_next: assert property (p_view_next) else $error("next page view wrong");

  property p_ack_follow;
    @(posedge ref_clk) disable iff (!rstn)
      flp_burst_seen ##1 s_ability_read |=> reg_rdata[ACK_BIT] == $past(flp_burst_ack, 2);
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack bit not from burst");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!rstn)
      s_base_view_read |=> !reg_rdata[BASE_RESERVED_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_exp_upper_zero;
    @(posedge ref_clk) disable iff (!rstn)
      s_exp_read |=> reg_rdata[15:5] == 11'h000 && reg_rdata[LOCAL_NP_BIT];
  endproperty
  a_exp_upper_zero: assert property (p_exp_upper_zero) else $error("expansion fixed bits wrong");

  property p_page_set;
    @(posedge ref_clk) disable iff (!rstn)
      (base_page_rx || next_page_rx) |=> page_received;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set");

  property p_page_cor;
    @(posedge ref_clk) disable iff (!rstn)
      (s_exp_read and !base_page_rx && !next_page_rx) |=> !page_received ##0 reg_rdata[PAGE_RX_BIT] == $past(page_received);
  endproperty
  a_page_cor: assert property (p_page_cor) else $error("clear on read failed");

  property p_pdf;
    @(posedge ref_clk) disable iff (!rstn)
      parallel_detect_fault ##1 s_exp_read |=> reg_rdata[PDF_BIT];
  endproperty
  a_pdf: assert property (p_pdf) else $error("fault bit missing");

  property p_write_inert;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr && !base_page_rx && !next_page_rx) |=> base_word == $past(base_word) && next_word == $past(next_word);
  endproperty
  a_write_inert: assert property (p_write_inert) else $error("write changed a field");

  property p_rvalid;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd));
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");

  property p_next_capture;
    @(posedge ref_clk) disable iff (!rstn)
      next_page_rx |=> next_word == $past(rx_page_word);
  endproperty
  a_next_capture: assert property (p_next_capture) else $error("next page not captured");

  property p_base_hold;
    @(posedge ref_clk) disable iff (!rstn)
      !base_page_rx |=> base_word == $past(base_word);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("base word changed without page");

  property p_next_hold;
    @(posedge ref_clk) disable iff (!rstn)
      !next_page_rx |=> next_word == $past(next_word);
  endproperty
  a_next_hold: assert property (p_next_hold) else $error("next word changed without page");

  property p_view_switch;
    @(posedge ref_clk) disable iff (!rstn)
      an_done_with_np |=> page_view_is_next;
  endproperty
  a_view_switch: assert property (p_view_switch) else $error("next view not selected");

  property p_view_base;
    @(posedge ref_clk) disable iff (!rstn)
      !an_done_with_np |=> !page_view_is_next;
  endproperty
  a_view_base: assert property (p_view_base) else $error("base view not selected");

  property p_ack_capture;
    @(posedge ref_clk) disable iff (!rstn)
      flp_burst_seen |=> partner_ack == $past(flp_burst_ack);
  endproperty
  a_ack_capture: assert property (p_ack_capture) else $error("ack not taken from burst");

  property p_ack_hold;
    @(posedge ref_clk) disable iff (!rstn)
      !flp_burst_seen |=> partner_ack == $past(partner_ack);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack changed without burst");

  property p_ack_in_view;
    @(posedge ref_clk) disable iff (!rstn)
      s_ability_read |=> reg_rdata[ACK_BIT] == $past(partner_ack);
  endproperty
  a_ack_in_view: assert property (p_ack_in_view) else $error("ack bit not shown");

  property p_selector;
    @(posedge ref_clk) disable iff (!rstn)
      s_base_view_read |=> reg_rdata[SELECTOR_MSB:0] == $past(base_word[SELECTOR_MSB:0]);
  endproperty
  a_selector: assert property (p_selector) else $error("selector field wrong");

  property p_base_fields;
    @(posedge ref_clk) disable iff (!rstn)
      s_base_view_read |=> reg_rdata[11:5] == $past(base_word[11:5]) && reg_rdata[15] == $past(base_word[15]);
  endproperty
  a_base_fields: assert property (p_base_fields) else $error("base ability fields wrong");

  property p_remote_fault;
    @(posedge ref_clk) disable iff (!rstn)
      s_base_view_read |=> reg_rdata[REMOTE_FAULT_BIT] == $past(base_word[REMOTE_FAULT_BIT]);
  endproperty
  a_remote_fault: assert property (p_remote_fault) else $error("remote fault bit wrong");

  property p_msg_flag;
    @(posedge ref_clk) disable iff (!rstn)
      s_next_view_read |=> reg_rdata[MESSAGE_PAGE_BIT] == $past(next_word[MESSAGE_PAGE_BIT]);
  endproperty
  a_msg_flag: assert property (p_msg_flag) else $error("message flag wrong");

  property p_comply;
    @(posedge ref_clk) disable iff (!rstn)
      s_next_view_read |=> reg_rdata[CAN_COMPLY_BIT] == $past(next_word[CAN_COMPLY_BIT]);
  endproperty
  a_comply: assert property (p_comply) else $error("comply bit wrong");

  property p_toggle;
    @(posedge ref_clk) disable iff (!rstn)
      s_next_view_read |=> reg_rdata[TOGGLE_BIT] == $past(next_word[TOGGLE_BIT]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit wrong");

  property p_next_np;
    @(posedge ref_clk) disable iff (!rstn)
      s_next_view_read |=> reg_rdata[NEXT_PAGE_BIT] == $past(next_word[NEXT_PAGE_BIT]);
  endproperty
  a_next_np: assert property (p_next_np) else $error("next view page bit wrong");

  property p_partner_np;
    @(posedge ref_clk) disable iff (!rstn)
      s_exp_read |=> reg_rdata[PARTNER_NP_BIT] == $past(base_word[NEXT_PAGE_BIT]);
  endproperty
  a_partner_np: assert property (p_partner_np) else $error("partner next page bit wrong");

  property p_local_np;
    @(posedge ref_clk) disable iff (!rstn)
      s_exp_read |=> reg_rdata[LOCAL_NP_BIT] == LOCAL_NP_VALUE;
  endproperty
  a_local_np: assert property (p_local_np) else $error("local next page bit wrong");

  property p_partner_an;
    @(posedge ref_clk) disable iff (!rstn)
      s_exp_read |=> reg_rdata[PARTNER_AN_BIT] == $past(partner_negotiation_capable, 2);
  endproperty
  a_partner_an: assert property (p_partner_an) else $error("partner negotiation bit wrong");

  property p_pdf_follow;
    @(posedge ref_clk) disable iff (!rstn)
      s_exp_read |=> reg_rdata[PDF_BIT] == $past(parallel_detect_fault, 2);
  endproperty
  a_pdf_follow: assert property (p_pdf_follow) else $error("fault bit does not follow");

  property p_page_hold;
    @(posedge ref_clk) disable iff (!rstn)
      (!base_page_rx && !next_page_rx && !read_expansion) |=> page_received == $past(page_received);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page flag changed alone");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr != PARTNER_ABILITY_ADDR && reg_addr != EXPANSION_STATUS_ADDR) |=> reg_rdata == UNMAPPED_READ_VALUE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // autoneg_partner_status_regs
`default_nettype wire

// [an_partner_pkg.sv]
// Constants for the partner ability and expansion status registers
package an_partner_pkg;
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 16;
  localparam logic [4:0] PARTNER_ABILITY_ADDR = 5'h05;
  localparam logic [4:0] EXPANSION_STATUS_ADDR = 5'h06;
  localparam int NEXT_PAGE_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int REMOTE_FAULT_BIT = 13;
  localparam int MESSAGE_PAGE_BIT = 13;
  localparam int BASE_RESERVED_BIT = 12;
  localparam int CAN_COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int SELECTOR_MSB = 4;
  localparam int CODE_MSB = 10;
  localparam int PDF_BIT = 4;
  localparam int PARTNER_NP_BIT = 3;
  localparam int LOCAL_NP_BIT = 2;
  localparam int PAGE_RX_BIT = 1;
  localparam int PARTNER_AN_BIT = 0;
  localparam logic [15:0] PAGE_WORD_RESET = 16'h0000;
  localparam logic [15:0] READ_DATA_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;
  localparam logic LOCAL_NP_VALUE = 1'b1;
  // Bit 12 of the base view always reads zero
  localparam logic [15:0] BASE_VIEW_MASK = 16'hEFFF;
endpackage

// [mgmt_host_model.sv]
// Management host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input wire logic ref_clk,
  input wire logic [an_partner_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [an_partner_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [an_partner_pkg::REG_DATA_W-1:0] reg_wdata
);
  import an_partner_pkg::*;
  logic timed_out = 1'b0;
  initial begin
    reg_addr = 5'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Address inverted when idle so stale values are not trusted
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(posedge ref_clk) #1;
    timed_out = (reg_rvalid !== 1'b1);
    d = reg_rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_wdata = d & 16'hBFFF;
    reg_wr = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // mgmt_host_model
`default_nettype wire

// [autoneg_partner_status_regs_bench.sv]
// Self-checking bench for the partner status registers
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_status_regs_bench;
  import an_partner_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_page_word = 16'h0000;
  logic reg_rd, reg_wr, reg_rvalid, page_view_is_next;
  logic base_page_rx = 1'b0, next_page_rx = 1'b0, flp_burst_seen = 1'b0, flp_burst_ack = 1'b0;
  logic an_done_with_np = 1'b0, parallel_detect_fault = 1'b0, partner_negotiation_capable = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  always #20 ref_clk = ~ref_clk;
  autoneg_partner_status_regs autoneg_partner_status_regs_i (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .base_page_rx(base_page_rx), .next_page_rx(next_page_rx),
    .rx_page_word(rx_page_word), .flp_burst_seen(flp_burst_seen), .flp_burst_ack(flp_burst_ack),
    .an_done_with_np(an_done_with_np), .parallel_detect_fault(parallel_detect_fault),
    .partner_negotiation_capable(partner_negotiation_capable), .page_view_is_next(page_view_is_next));
  mgmt_host_model mgmt_host_model_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp || mgmt_host_model_i.timed_out) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A lost answer counts and ends the run
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    mgmt_host_model_i.rd(a, d);
    chk(d, exp);
    if (mgmt_host_model_i.timed_out) summarize();
  endtask
  task automatic page(input logic nxt, input logic [15:0] w);
    @(posedge ref_clk) #1;
    rx_page_word = w;
    next_page_rx = nxt;
    base_page_rx = !nxt;
    @(posedge ref_clk) #1;
    next_page_rx = 1'b0;
    base_page_rx = 1'b0;
    rx_page_word = ~w;
  endtask
  task automatic burst(input logic a);
    @(posedge ref_clk) #1;
    flp_burst_ack = a;
    flp_burst_seen = 1'b1;
    @(posedge ref_clk) #1;
    flp_burst_seen = 1'b0;
  endtask
  task automatic t_reset();
    rchk(5'h05, 16'h0000);
    rchk(5'h06, 16'h0004);
    rchk(5'h04, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_base();
    page(1'b0, 16'hFFFF);
    rchk(5'h05, 16'hAFFF);
    burst(1'b1);
    rchk(5'h05, 16'hEFFF);
    rchk(5'h06, 16'h000E);
    rchk(5'h06, 16'h000C);
    $display("test base page done");
  endtask
  task automatic t_status();
    parallel_detect_fault = 1'b1;
    partner_negotiation_capable = 1'b1;
    mgmt_host_model_i.wr(5'h06, 16'hFFFF);
    mgmt_host_model_i.wr(5'h05, 16'hFFFF);
    rchk(5'h06, 16'h001D);
    rchk(5'h05, 16'hEFFF);
    parallel_detect_fault = 1'b0;
    rchk(5'h06, 16'h000D);
    $display("test status done");
  endtask
  task automatic t_next();
    an_done_with_np = 1'b1;
    page(1'b1, 16'h2801);
    chk({15'h0000, page_view_is_next}, 16'h0001);
    rchk(5'h05, 16'h6801);
    burst(1'b0);
    page(1'b1, 16'h9234);
    rchk(5'h05, 16'h9234);
    rchk(5'h06, 16'h000F);
    $display("test next page done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_base();
    t_status();
    t_next();
    summarize();
  end
endmodule // autoneg_partner_status_regs_bench
`default_nettype wire
